// ===== dv/phy_link_asserts.sv
// Checker on the link pins between the two ends
module phy_link_asserts
  import phy_rx_pkg::*;
#(
  parameter int MDC_HALF = MDC_HALF_DEF_CYC,
  parameter int HALF_10 = RXCLK_HALF_10_CYC,
  parameter int HALF_100 = RXCLK_HALF_100_CYC,
  parameter int HALF_1000 = RXCLK_HALF_1000_CYC
) (
  // Clock, reset and mode
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire phy_rx_pkg::mac_mode_t mode,
  input wire phy_rx_pkg::speed_t speed,
  input wire logic full_duplex,
  // Line activity
  input wire logic tx_active,
  input wire logic rx_carrier,
  input wire logic packet_detect,
  // Link pins
  input wire logic rx_clk,
  input wire logic [7:0] rxd,
  input wire logic rx_dv_ctrl,
  input wire logic rx_er,
  input wire logic col,
  input wire logic crs,
  input wire logic mdc,
  input wire logic mdio_st_o,
  input wire logic mdio_st_oe,
  input wire logic mdio_dev_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic rd_r, md_r, rseen_r, mseen_r;
  int rcnt_r, mcnt_r, half;
  assign half = (speed == SPEED_10) ? HALF_10 : (speed == SPEED_100) ? HALF_100 : HALF_1000;
  // Level lengths; the first level after reset is partial, so not judged
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {rd_r, md_r, rseen_r, mseen_r} <= 4'h0;
      rcnt_r <= 0;
      mcnt_r <= 0;
    end else begin
      rd_r <= rx_clk;
      md_r <= mdc;
      rseen_r <= rseen_r | (rx_clk != rd_r);
      mseen_r <= mseen_r | (mdc != md_r);
      rcnt_r <= (rx_clk != rd_r) ? 1 : rcnt_r + 1;
      mcnt_r <= (mdc != md_r) ? 1 : mcnt_r + 1;
    end
  end
  chk_mii_upper_zero: assert property (mode == MODE_MII |-> rxd[7:4] == 4'h0)
    else $error("upper lanes driven in nibble mode");
  chk_rx_on_fall: assert property ($changed({rxd, rx_er, rx_dv_ctrl})
    && mode != MODE_RGMII |-> $fell(rx_clk))
    else $error("receive pins moved off the clock fall");
  chk_rgmii_unused: assert property (mode == MODE_RGMII |-> !rx_er && !col && !crs)
    else $error("dedicated status pin active in reduced mode");
  chk_col_half: assert property (!full_duplex && mode != MODE_RGMII
    |-> col == $past(tx_active && rx_carrier))
    else $error("collision pin wrong in half duplex");
  chk_col_fd_low: assert property (full_duplex |-> !col)
    else $error("collision pin high in full duplex");
  chk_crs_half: assert property (!full_duplex && mode != MODE_RGMII
    |-> crs == $past(tx_active || rx_carrier))
    else $error("carrier pin wrong in half duplex");
  chk_crs_fd_pkt: assert property (full_duplex && mode != MODE_RGMII
    && speed != SPEED_1000 |-> crs == $past(packet_detect))
    else $error("carrier pin not following packets in full duplex");
  chk_rxclk_half: assert property (rseen_r && rx_clk != rd_r |-> rcnt_r == half)
    else $error("receive clock half period wrong");
  chk_mdc_half: assert property (mseen_r && mdc != md_r |-> mcnt_r == MDC_HALF)
    else $error("management clock half period wrong");
  chk_st_after_fall: assert property ($changed({mdio_st_o, mdio_st_oe})
    |-> !mdc && ($past(mdc) || $past(mdc, 2)))
    else $error("station data moved away from the clock fall");
  chk_mdio_one_driver: assert property (!(mdio_st_oe && mdio_dev_oe))
    else $error("both ends drive the management line");
  cov_rgmii_valid: cover property (mode == MODE_RGMII && $rose(rx_dv_ctrl));
  cov_collision: cover property ($rose(col));
  cov_dev_drive: cover property ($rose(mdio_dev_oe));
endmodule

// ===== dv/tb_phy_rx_status_and_mgmt_pins.sv
// Testbench joining the two ends through the link
module tb_phy_rx_status_and_mgmt_pins;
  timeunit 1ns;
  timeprecision 1ns;
  import phy_rx_pkg::*;
  logic clk_sys, rst_n, full_duplex, rx_valid, rx_error, rx_take;
  mac_mode_t mode;
  speed_t speed;
  logic [7:0] rx_byte, rx_data;
  logic tx_active, rx_carrier, packet_detect, rx_data_stb, rx_data_err, collision, carrier;
  pin_func_t pin_sel [GPIO_PINS];
  logic [GPIO_PINS-1:0] gpio;
  logic mgmt_out_bit, mgmt_drive, mgmt_in_bit, mgmt_in_stb;
  logic st_out_bit, st_drive, st_bit_take, st_in_bit, st_in_stb;
  logic [8:0] q[$];
  logic [5:0] gexp = 6'b101100;
  int failures = 0;
  int total_checks = 0;
  phy_link_if phy_link_if_inst ();
  phy_rx_end phy_rx_end_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(phy_link_if_inst.phy),
    .mode(mode), .speed(speed), .full_duplex(full_duplex), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_error(rx_error), .rx_take(rx_take), .tx_active(tx_active),
    .rx_carrier(rx_carrier), .packet_detect(packet_detect),
    .general_pin_function_select(pin_sel), .gpio(gpio), .mgmt_out_bit(mgmt_out_bit),
    .mgmt_drive(mgmt_drive), .mgmt_in_bit(mgmt_in_bit), .mgmt_in_stb(mgmt_in_stb));
  mac_rx_end mac_rx_end_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(phy_link_if_inst.mac),
    .mode(mode), .speed(speed), .full_duplex(full_duplex), .rx_data(rx_data),
    .rx_data_stb(rx_data_stb), .rx_data_err(rx_data_err), .collision(collision),
    .carrier(carrier), .st_out_bit(st_out_bit), .st_drive(st_drive),
    .st_bit_take(st_bit_take), .st_in_bit(st_in_bit), .st_in_stb(st_in_stb));
  phy_link_asserts phy_link_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n), .mode(mode),
    .speed(speed), .full_duplex(full_duplex), .tx_active(tx_active),
    .rx_carrier(rx_carrier), .packet_detect(packet_detect),
    .rx_clk(phy_link_if_inst.rx_clk), .rxd(phy_link_if_inst.rxd),
    .rx_dv_ctrl(phy_link_if_inst.rx_dv_ctrl), .rx_er(phy_link_if_inst.rx_er),
    .col(phy_link_if_inst.col), .crs(phy_link_if_inst.crs), .mdc(phy_link_if_inst.mdc),
    .mdio_st_o(phy_link_if_inst.mdio_st_o), .mdio_st_oe(phy_link_if_inst.mdio_st_oe),
    .mdio_dev_oe(phy_link_if_inst.mdio_dev_oe));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    if (rx_data_stb === 1'b1) q.push_back({rx_data_err, rx_data});
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Ends on the edge that samples the pulse
  task automatic wait_hi(ref logic s);
    int n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (s !== 1'b1 && n < 400);
    if (s !== 1'b1) begin
      failures++;
      print_verdict();
    end else begin
      @(posedge clk_sys);
    end
  endtask
  task automatic cfg(input mac_mode_t m, input speed_t s, input logic fd);
    rst_n <= 1'b0;
    mode <= m;
    speed <= s;
    full_duplex <= fd;
    {tx_active, rx_carrier, packet_detect} <= 3'b000;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    q.delete();
  endtask
  task automatic put(input logic [7:0] b, input logic v, input logic e);
    rx_byte <= b;
    rx_valid <= v;
    rx_error <= e;
    wait_hi(rx_take);
  endtask
  // Pins change on the taking edge, so they are settled half a cycle later
  task automatic put_w(input logic [7:0] b, input logic v, input logic e, input logic [9:0] x);
    put(b, v, e);
    @(negedge clk_sys);
    check(16'({phy_link_if_inst.rx_dv_ctrl, phy_link_if_inst.rx_er, phy_link_if_inst.rxd}),
      16'(x));
    @(posedge clk_sys);
  endtask
  task automatic expect_rx(input logic [8:0] exp);
    int n = 0;
    while (q.size() == 0 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (q.size() == 0) begin
      failures++;
      print_verdict();
    end else begin
      check(16'(q.pop_front()), 16'(exp));
      @(posedge clk_sys);
    end
  endtask
  // Pin path is one cycle, the end's synchroniser four more
  task automatic act(input logic [2:0] a, input logic [3:0] exp);
    {tx_active, rx_carrier, packet_detect} <= a;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    check(16'({phy_link_if_inst.col, phy_link_if_inst.crs, collision, carrier}),
      16'(exp));
    @(posedge clk_sys);
  endtask
  task automatic st_bit(input logic d, input logic b);
    st_drive <= d;
    st_out_bit <= b;
    // A take pulse from this very edge would confirm the old bit
    @(posedge clk_sys);
    wait_hi(st_bit_take);
  endtask
  task automatic dev_bit(input logic d, input logic b);
    mgmt_drive <= d;
    mgmt_out_bit <= b;
    wait_hi(st_in_stb);
    wait_hi(st_in_stb);
  endtask
  initial begin
    {rx_byte, rx_valid, rx_error, mgmt_out_bit, mgmt_drive, st_out_bit, st_drive} <= 14'h0;
    pin_sel <= '{PIN_LOW, PIN_LOW};
    cfg(MODE_GMII, SPEED_100, 1'b0);
    put_w(8'ha5, 1'b1, 1'b0, 10'h2a5);
    put(8'h11, 1'b0, 1'b0);
    put_w(8'h3c, 1'b1, 1'b1, 10'h33c);
    put(8'h00, 1'b0, 1'b0);
    expect_rx(9'h0a5);
    expect_rx(9'h13c);
    for (int i = 0; i < 4; i++) begin
      act({i[1], i[0], 1'b0}, {2{i[1] & i[0], i[1] | i[0]}});
    end
    for (int i = 0; i < 6; i++) begin
      pin_sel <= '{pin_func_t'(5 - i), pin_func_t'(i)};
      repeat (3) @(posedge clk_sys);
      check(16'(gpio), 16'({gexp[i], gexp[5 - i]}));
    end
    st_bit(1'b1, 1'b1);
    wait_hi(mgmt_in_stb);
    check(16'(mgmt_in_bit), 16'h1);
    st_bit(1'b1, 1'b0);
    wait_hi(mgmt_in_stb);
    check(16'(mgmt_in_bit), 16'h0);
    st_bit(1'b0, 1'b0);
    dev_bit(1'b1, 1'b1);
    check(16'(st_in_bit), 16'h1);
    dev_bit(1'b1, 1'b0);
    check(16'(st_in_bit), 16'h0);
    dev_bit(1'b0, 1'b0);
    check(16'(st_in_bit), 16'h1);
    cfg(MODE_MII, SPEED_10, 1'b0);
    put_w(8'hb7, 1'b1, 1'b0, 10'h207);
    put(8'h00, 1'b0, 1'b0);
    expect_rx(9'h007);
    cfg(MODE_GMII, SPEED_100, 1'b1);
    for (int i = 0; i < 8; i++) begin
      act(3'(i), {1'b0, i[0], 1'b0, i[0]});
    end
    cfg(MODE_GMII, SPEED_1000, 1'b1);
    act(3'b111, 4'h0);
    cfg(MODE_RGMII, SPEED_1000, 1'b0);
    act(3'b110, 4'h0);
    put(8'ha5, 1'b1, 1'b0);
    put(8'h5a, 1'b0, 1'b1);
    put(8'hc3, 1'b1, 1'b1);
    put(8'h00, 1'b0, 1'b0);
    expect_rx(9'h0a5);
    expect_rx(9'h1c3);
    print_verdict();
  end
endmodule

// ===== hw/mac_rx_end.sv
// MAC end: samples receive pins, makes management clock, drives its data turns
module mac_rx_end
  import phy_rx_pkg::*;
#(
  parameter int MDC_HALF = MDC_HALF_DEF_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link pins
  phy_link_if.mac link,
  // Operating mode
  input wire phy_rx_pkg::mac_mode_t mode,
  input wire phy_rx_pkg::speed_t speed,
  input wire logic full_duplex,
  // Received stream
  output logic [7:0] rx_data,
  output logic rx_data_stb,
  output logic rx_data_err,
  // Line status
  output logic collision,
  output logic carrier,
  // Management user side
  input wire logic st_out_bit,
  input wire logic st_drive,
  output logic st_bit_take,
  output logic st_in_bit,
  output logic st_in_stb
);
  import phy_rx_pkg::*;

  localparam int W = 14;
  localparam int HALF = (MDC_HALF > MDC_HALF_MIN_CYC) ? MDC_HALF : MDC_HALF_MIN_CYC;

  // Pin order: clk, ctrl, er, col, crs, mdio, rxd[7:0]
  logic [W-1:0] pins;
  logic [W-1:0] s0_r, s1_r, s2_r;
  logic [W-1:0] lvl_r, lvl_nxt;

  assign pins = {link.rx_clk, link.rx_dv_ctrl, link.rx_er, link.col, link.crs, link.mdio,
                 link.rxd};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s0_r <= '0;
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s0_r <= pins;
      s1_r <= s0_r;
      s2_r <= s1_r;
    end
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      lvl_nxt[i] = (s1_r[i] == s2_r[i]) ? s2_r[i] : lvl_r[i];
    end
  end

  logic clk_rise, clk_fall;
  logic [7:0] data_r, data_nxt;
  logic stb_r, stb_nxt;
  logic err_r, err_nxt;
  logic dv_hold_r, dv_hold_nxt;
  logic [3:0] lo_r, lo_nxt;
  logic col_r, col_nxt;
  logic crs_r, crs_nxt;

  always_comb begin
    clk_rise = lvl_nxt[13] & ~lvl_r[13];
    clk_fall = ~lvl_nxt[13] & lvl_r[13];
    data_nxt = data_r;
    stb_nxt = 1'b0;
    err_nxt = err_r;
    dv_hold_nxt = dv_hold_r;
    lo_nxt = lo_r;
    if (mode == MODE_RGMII) begin
      // Pre-edge levels: the far end launches new values with every clock edge
      if (clk_rise) begin
        dv_hold_nxt = lvl_r[12];
        lo_nxt = lvl_r[3:0];
      end else if (clk_fall && dv_hold_r) begin
        data_nxt = {lvl_r[3:0], lo_r};
        err_nxt = lvl_r[12] ^ dv_hold_r;
        stb_nxt = 1'b1;
      end
    end else if (clk_rise && lvl_nxt[12]) begin
      data_nxt = (mode == MODE_MII) ? {4'h0, lvl_nxt[3:0]} : lvl_nxt[7:0];
      err_nxt = lvl_nxt[11];
      stb_nxt = 1'b1;
    end
    col_nxt = (mode != MODE_RGMII) & lvl_nxt[10];
    // Carrier has no meaning in gigabit full duplex
    crs_nxt = (mode != MODE_RGMII) & lvl_nxt[9] &
              ~(full_duplex & (speed == SPEED_1000));
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lvl_r <= '0;
      data_r <= DATA_RESET;
      stb_r <= BIT_RESET;
      err_r <= BIT_RESET;
      dv_hold_r <= BIT_RESET;
      lo_r <= 4'h0;
      col_r <= BIT_RESET;
      crs_r <= BIT_RESET;
    end else begin
      lvl_r <= lvl_nxt;
      data_r <= data_nxt;
      stb_r <= stb_nxt;
      err_r <= err_nxt;
      dv_hold_r <= dv_hold_nxt;
      lo_r <= lo_nxt;
      col_r <= col_nxt;
      crs_r <= crs_nxt;
    end
  end

  // Management clock divider; station changes data on the falling edge
  logic [7:0] mdiv_r, mdiv_nxt;
  logic mdc_r, mdc_nxt;
  logic so_r, so_nxt;
  logic soe_r, soe_nxt;
  logic take_r, take_nxt;
  logic ib_r, ib_nxt;
  logic istb_r, istb_nxt;

  always_comb begin
    mdiv_nxt = mdiv_r + 8'h01;
    mdc_nxt = mdc_r;
    so_nxt = so_r;
    soe_nxt = soe_r;
    take_nxt = 1'b0;
    ib_nxt = ib_r;
    istb_nxt = 1'b0;
    if (mdiv_r >= 8'(HALF - 1)) begin
      mdiv_nxt = 8'h00;
      mdc_nxt = ~mdc_r;
      if (mdc_r) begin
        so_nxt = st_out_bit;
        soe_nxt = st_drive;
        take_nxt = 1'b1;
      end else begin
        // Freshest settled level; a reply launched on the previous rise lands just in time
        ib_nxt = lvl_nxt[8];
        istb_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mdiv_r <= 8'h00;
      mdc_r <= BIT_RESET;
      so_r <= MDIO_IDLE;
      soe_r <= BIT_RESET;
      take_r <= BIT_RESET;
      ib_r <= BIT_RESET;
      istb_r <= BIT_RESET;
    end else begin
      mdiv_r <= mdiv_nxt;
      mdc_r <= mdc_nxt;
      so_r <= so_nxt;
      soe_r <= soe_nxt;
      take_r <= take_nxt;
      ib_r <= ib_nxt;
      istb_r <= istb_nxt;
    end
  end

  assign link.mdc = mdc_r;
  assign link.mdio_st_o = so_r;
  assign link.mdio_st_oe = soe_r;
  assign rx_data = data_r;
  assign rx_data_stb = stb_r;
  assign rx_data_err = err_r;
  assign collision = col_r;
  assign carrier = crs_r;
  assign st_bit_take = take_r;
  assign st_in_bit = ib_r;
  assign st_in_stb = istb_r;
endmodule

// ===== hw/phy_link_if.sv
// Pin-level link between the PHY receive end and the MAC end
interface phy_link_if;
  logic rx_clk;
  logic [7:0] rxd;
  logic rx_dv_ctrl;
  logic rx_er;
  logic col;
  logic crs;
  logic mdc;
  logic mdio_st_o;
  logic mdio_st_oe;
  logic mdio_dev_o;
  logic mdio_dev_oe;
  logic mdio;

  // Pulled-up shared line; station wins if both drive by mistake
  assign mdio = mdio_st_oe ? mdio_st_o : (mdio_dev_oe ? mdio_dev_o : 1'b1);

  modport phy (output rx_clk, rxd, rx_dv_ctrl, rx_er, col, crs, mdio_dev_o, mdio_dev_oe,
               input mdc, mdio);
  modport mac (input rx_clk, rxd, rx_dv_ctrl, rx_er, col, crs, mdio,
               output mdc, mdio_st_o, mdio_st_oe);
endinterface

// ===== hw/phy_rx_end.sv
// PHY end: receive clock, status pins, general pins and management pin
module phy_rx_end
  import phy_rx_pkg::*;
#(
  parameter int HALF_10 = RXCLK_HALF_10_CYC,
  parameter int HALF_100 = RXCLK_HALF_100_CYC,
  parameter int HALF_1000 = RXCLK_HALF_1000_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link pins
  phy_link_if.phy link,
  // Operating mode
  input wire phy_rx_pkg::mac_mode_t mode,
  input wire phy_rx_pkg::speed_t speed,
  input wire logic full_duplex,
  // Receive stream from the line side
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_error,
  output logic rx_take,
  // Line activity
  input wire logic tx_active,
  input wire logic rx_carrier,
  input wire logic packet_detect,
  // General purpose pins
  input wire phy_rx_pkg::pin_func_t general_pin_function_select [GPIO_PINS],
  output logic [GPIO_PINS-1:0] gpio,
  // Management user side
  input wire logic mgmt_out_bit,
  input wire logic mgmt_drive,
  output logic mgmt_in_bit,
  output logic mgmt_in_stb
);
  import phy_rx_pkg::*;

  // Receive clock divider
  logic [7:0] div_r, div_nxt;
  logic rx_clk_r, rx_clk_nxt;
  logic [7:0] half_len;
  logic rise_now, fall_now;

  always_comb begin
    case (speed)
      SPEED_10: half_len = 8'(HALF_10);
      SPEED_100: half_len = 8'(HALF_100);
      default: half_len = 8'(HALF_1000);
    endcase
  end

  always_comb begin
    div_nxt = div_r + 8'h01;
    rx_clk_nxt = rx_clk_r;
    rise_now = 1'b0;
    fall_now = 1'b0;
    if (div_r >= half_len - 8'h01) begin
      div_nxt = 8'h00;
      rx_clk_nxt = ~rx_clk_r;
      rise_now = ~rx_clk_r;
      fall_now = rx_clk_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 8'h00;
      rx_clk_r <= BIT_RESET;
    end else begin
      div_r <= div_nxt;
      rx_clk_r <= rx_clk_nxt;
    end
  end

  // Receive data and control; MII/GMII values change on the clock fall so the far end
  // sees them settled at the rise it samples on; RGMII values change on both edges
  logic [7:0] rxd_r, rxd_nxt;
  logic ctrl_r, ctrl_nxt;
  logic er_r, er_nxt;
  logic [3:0] hi_nib_r, hi_nib_nxt;
  logic dv_hold_r, dv_hold_nxt;
  logic er_hold_r, er_hold_nxt;

  assign rx_take = fall_now;

  always_comb begin
    rxd_nxt = rxd_r;
    ctrl_nxt = ctrl_r;
    er_nxt = er_r;
    hi_nib_nxt = hi_nib_r;
    dv_hold_nxt = dv_hold_r;
    er_hold_nxt = er_hold_r;
    if (mode == MODE_RGMII) begin
      er_nxt = 1'b0;
      if (fall_now) begin
        rxd_nxt = {4'h0, rx_byte[3:0]};
        ctrl_nxt = rx_valid;
        hi_nib_nxt = rx_byte[7:4];
        dv_hold_nxt = rx_valid;
        er_hold_nxt = rx_error;
      end else if (rise_now) begin
        rxd_nxt = {4'h0, hi_nib_r};
        ctrl_nxt = dv_hold_r ^ er_hold_r;
      end
    end else if (fall_now) begin
      rxd_nxt = (mode == MODE_MII) ? {4'h0, rx_byte[3:0]} : rx_byte;
      ctrl_nxt = rx_valid;
      er_nxt = rx_error;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxd_r <= DATA_RESET;
      ctrl_r <= BIT_RESET;
      er_r <= BIT_RESET;
      hi_nib_r <= 4'h0;
      dv_hold_r <= BIT_RESET;
      er_hold_r <= BIT_RESET;
    end else begin
      rxd_r <= rxd_nxt;
      ctrl_r <= ctrl_nxt;
      er_r <= er_nxt;
      hi_nib_r <= hi_nib_nxt;
      dv_hold_r <= dv_hold_nxt;
      er_hold_r <= er_hold_nxt;
    end
  end

  // Collision and carrier, on the system clock with no tie to rx_clk
  logic col_r, col_nxt;
  logic crs_r, crs_nxt;
  logic [GPIO_PINS-1:0] gpio_r, gpio_nxt;

  always_comb begin
    col_nxt = 1'b0;
    crs_nxt = 1'b0;
    if (mode != MODE_RGMII) begin
      if (!full_duplex) begin
        col_nxt = tx_active & rx_carrier;
        crs_nxt = tx_active | rx_carrier;
      end else if (speed != SPEED_1000) begin
        crs_nxt = packet_detect;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < GPIO_PINS; i++) begin
      case (general_pin_function_select[i])
        PIN_RX_ERR: gpio_nxt[i] = er_r;
        PIN_COLLISION: gpio_nxt[i] = col_r;
        PIN_CARRIER: gpio_nxt[i] = crs_r;
        PIN_RX_VALID: gpio_nxt[i] = ctrl_r;
        PIN_HIGH: gpio_nxt[i] = 1'b1;
        default: gpio_nxt[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      col_r <= BIT_RESET;
      crs_r <= BIT_RESET;
      gpio_r <= '0;
    end else begin
      col_r <= col_nxt;
      crs_r <= crs_nxt;
      gpio_r <= gpio_nxt;
    end
  end

  // Management pins: management clock arrives from outside this domain
  logic [SYNC_STAGES-1:0] mdc_s_r, mdio_s_r;
  logic mdc_lvl_r, mdc_lvl_nxt;
  logic mdio_lvl_r, mdio_lvl_nxt;
  logic mdo_r, mdo_nxt;
  logic mdoe_r, mdoe_nxt;
  logic in_bit_r, in_bit_nxt;
  logic in_stb_r, in_stb_nxt;
  logic mdc_rise;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mdc_s_r <= '0;
      mdio_s_r <= '1;
    end else begin
      mdc_s_r <= {mdc_s_r[SYNC_STAGES-2:0], link.mdc};
      mdio_s_r <= {mdio_s_r[SYNC_STAGES-2:0], link.mdio};
    end
  end

  always_comb begin
    mdc_lvl_nxt = (mdc_s_r[1] == mdc_s_r[2]) ? mdc_s_r[2] : mdc_lvl_r;
    mdio_lvl_nxt = (mdio_s_r[1] == mdio_s_r[2]) ? mdio_s_r[2] : mdio_lvl_r;
    mdc_rise = mdc_lvl_nxt & ~mdc_lvl_r;
    mdo_nxt = mdo_r;
    mdoe_nxt = mdoe_r;
    in_bit_nxt = in_bit_r;
    in_stb_nxt = 1'b0;
    if (mdc_rise) begin
      in_bit_nxt = mdio_lvl_r;
      in_stb_nxt = 1'b1;
      mdo_nxt = mgmt_out_bit;
      mdoe_nxt = mgmt_drive;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mdc_lvl_r <= BIT_RESET;
      mdio_lvl_r <= MDIO_IDLE;
      mdo_r <= MDIO_IDLE;
      mdoe_r <= BIT_RESET;
      in_bit_r <= BIT_RESET;
      in_stb_r <= BIT_RESET;
    end else begin
      mdc_lvl_r <= mdc_lvl_nxt;
      mdio_lvl_r <= mdio_lvl_nxt;
      mdo_r <= mdo_nxt;
      mdoe_r <= mdoe_nxt;
      in_bit_r <= in_bit_nxt;
      in_stb_r <= in_stb_nxt;
    end
  end

  assign link.rx_clk = rx_clk_r;
  assign link.rxd = rxd_r;
  assign link.rx_dv_ctrl = ctrl_r;
  assign link.rx_er = er_r;
  assign link.col = col_r;
  assign link.crs = crs_r;
  assign link.mdio_dev_o = mdo_r;
  assign link.mdio_dev_oe = mdoe_r;
  assign gpio = gpio_r;
  assign mgmt_in_bit = in_bit_r;
  assign mgmt_in_stb = in_stb_r;
endmodule

// ===== hw/phy_rx_pkg.sv
// Shared constants and types for the receive status and management link
// Functional notes
// - MII/GMII: data valid high during valid data
// - RGMII: valid and error share one control line
// - Receive error high, synchronous to receive clock
// - RGMII: error, collision, carrier lines unused
// - Half duplex: collision high on simultaneous activity
// - Collision is asynchronous; MAC synchronises it
// - Full duplex: collision held low
// - Half duplex: carrier high on any activity
// - 10/100 full duplex: carrier on received packet
// - MAC ignores carrier in gigabit full duplex
// - Management clock at most 25 MHz, may pause
// - Management data sampled and driven on management clock
// - Each party drives management data only in turn
// - General pins select function by mux setting
// - Receive clock follows speed: 2.5, 25, 125 MHz; code gives 2.5, 6.25, 6.25 MHz (two-cycle half minimum)
package phy_rx_pkg;
  typedef enum logic [1:0] {MODE_MII, MODE_GMII, MODE_RGMII} mac_mode_t;
  typedef enum logic [1:0] {SPEED_10, SPEED_100, SPEED_1000} speed_t;
  typedef enum logic [2:0] {
    PIN_LOW, PIN_RX_ERR, PIN_COLLISION, PIN_CARRIER, PIN_RX_VALID, PIN_HIGH
  } pin_func_t;

  localparam int SYS_PERIOD_NS = 40;
  localparam int RXCLK_PERIOD_10_NS = 400;
  localparam int RXCLK_PERIOD_100_NS = 40;
  localparam int RXCLK_PERIOD_1000_NS = 8;
  // Pin sampling needs each level to stand two system cycles
  localparam int MIN_HALF_CYC = 2;
  localparam int RXCLK_HALF_10_CYC = (RXCLK_PERIOD_10_NS / 2 / SYS_PERIOD_NS > MIN_HALF_CYC)
                                     ? RXCLK_PERIOD_10_NS / 2 / SYS_PERIOD_NS : MIN_HALF_CYC;
  localparam int RXCLK_HALF_100_CYC = (RXCLK_PERIOD_100_NS / 2 / SYS_PERIOD_NS > MIN_HALF_CYC)
                                      ? RXCLK_PERIOD_100_NS / 2 / SYS_PERIOD_NS : MIN_HALF_CYC;
  localparam int RXCLK_HALF_1000_CYC = (RXCLK_PERIOD_1000_NS / 2 / SYS_PERIOD_NS > MIN_HALF_CYC)
                                       ? RXCLK_PERIOD_1000_NS / 2 / SYS_PERIOD_NS : MIN_HALF_CYC;
  localparam int MDC_MIN_PERIOD_NS = 40;
  localparam int MDC_HALF_MIN_CYC = (MDC_MIN_PERIOD_NS + 2 * SYS_PERIOD_NS - 1) / (2 * SYS_PERIOD_NS);
  localparam int MDC_HALF_DEF_CYC = 4;
  localparam int SYNC_STAGES = 3;
  localparam int GPIO_PINS = 2;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic BIT_RESET = 1'b0;
  localparam logic MDIO_IDLE = 1'b1;
endpackage
